// ==== hw/dram_cmd_datapath.sv ====
/*
 Device side command decode, address handling and read/write bursts.
 Assumes controller pins are asynchronous to mclk_in and are sampled twice.
 // Operation
 // - Address width follows burst length and organisation
 // - Loop control powers up low, loop disabled
 // - External matching samples resistor, updates transparently
 // - Internal 50 ohm impedance, still recalibrated
 // - Multiplexed address: two halves, eleven lines
 // - Refresh takes one cycle, even multiplexed
 // - Fixed bit mapping of both address halves
 // - Terminate data and mask pins only
 // - Read data termination off while driving
 // - Deselect starts nothing, cancels nothing
 // - Read: select low, write, refresh high
 // - Read data after programmed read latency
 // - Valid flag rises before first beat
 // - Flag drops on last beat, pins float
 // - Output clock free-running, back-to-back reads
 // - Write: select, write low, refresh high
 // - Write data one cycle after read latency
 // - Masked beats leave memory unchanged
 // - Multiplexed mode adds one latency cycle
*/
`timescale 1ns/1ps
module dram_cmd_datapath #(
   parameter bit ORG_X18 = 1'b1,
   parameter int MEM_AW = 8,
   parameter int FIFO_DEPTH = 4,
   parameter int CAL_PERIOD = 256
) (
   input wire logic mclk_in,
   input wire logic rst_in,
   input wire logic clk_en_in,
   input wire logic chip_sel_n_in,
   input wire logic write_en_n_in,
   input wire logic refresh_n_in,
   input wire logic [dram_pkg::BANK_W-1:0] bank_in,
   input wire logic [dram_pkg::ADDR_W-1:0] addr_in,
   input wire logic [dram_pkg::DATA_W-1:0] write_data_in,
   input wire logic data_mask_in,
   input wire logic write_data_clock_in,
   input wire logic impedance_ref_pin_in,
   input wire logic internal_ref_cmp_in,
   output logic [dram_pkg::DATA_W-1:0] read_data_out,
   output logic read_data_oe_n_out,
   output logic read_valid_flag_out,
   output logic read_data_clock_out,
   output logic read_data_clock_n_out,
   output logic read_term_en_out,
   output logic write_term_en_out,
   output logic dll_locked_out,
   output logic mux_mode_out,
   output logic impedance_ext_out,
   output logic [dram_pkg::CODE_W-1:0] impedance_code_out,
   output logic refresh_pulse_out,
   output logic write_overrun_out
);
   import dram_pkg::*;

   generate
      if (MEM_AW < 1 || MEM_AW > 25) begin : g_bad_mem
         $error("dram_cmd_datapath memory address width out of range");
      end
   endgenerate

   typedef enum logic {PH_FIRST, PH_SECOND} phase_t;

   typedef struct packed {
      cmd_t c1;
      cmd_t c2;
      logic wck1;
      logic wck2;
      logic wck3;
      beat_t b1;
      beat_t b2;
      phase_t ph;
      cmd_kind_t pend;
      logic [BANK_W-1:0] pbank;
      logic [ADDR_W-1:0] pfirst;
      mode_t mode;
      logic [10:0] dll_cnt;
      logic dll_lock;
      pipe_t [PIPE_LEN-1:0] rp;
      pipe_t [PIPE_LEN-1:0] wp;
      logic r_act;
      logic [3:0] r_cnt;
      pipe_t r_cur;
      logic w_act;
      logic [3:0] w_cnt;
      pipe_t w_cur;
      beat_t hold;
      logic hold_v;
      logic overrun;
      logic [DATA_W-1:0] rdata;
      logic rd_oe_n;
      logic rvalid;
      logic qclk;
      logic qclk_n;
      logic rterm;
      logic wterm;
      logic ref_pulse;
   } state_t;

   state_t s_q;
   state_t s_d;
   logic [DATA_W-1:0] mem [2**MEM_AW];
   logic mem_we;
   logic [MEM_AW-1:0] mem_widx;
   logic [DATA_W-1:0] mem_wdata;
   logic f_in_ready;
   logic f_out_valid;
   beat_t f_out;
   logic [CODE_W-1:0] cal_code;

   function automatic logic [ADDR_W-1:0] addr_mask(input logic [1:0] bl, input logic x18);
      logic [ADDR_W-1:0] m;
      int w;
      w = ADDR_W - ((bl == BL_CODE_2) ? 0 : (bl == BL_CODE_4) ? 1 : 2) - (x18 ? 1 : 0);
      for (int i = 0; i < ADDR_W; i++) begin
         m[i] = (i < w);
      end
      return m;
   endfunction

   function automatic logic [ADDR_W-1:0] mux_join(input logic [ADDR_W-1:0] first,
                                                  input logic [ADDR_W-1:0] second);
      logic [ADDR_W-1:0] a;
      a = '0;
      for (int i = 0; i < MUX_LINES; i++) begin
         a[FIRST_MAP[i]] = first[FIRST_MAP[i]];
         a[SECOND_MAP[i]] = second[FIRST_MAP[i]];
      end
      return a;
   endfunction

   function automatic logic [MEM_AW-1:0] mem_index(input pipe_t p, input logic [3:0] beat);
      logic [24:0] sum;
      sum = {p.bank, p.addr} + 25'(beat);
      return sum[MEM_AW-1:0];
   endfunction

   beat_fifo #(
      .WIDTH($bits(beat_t)),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_in(mclk_in),
      .rst_in(rst_in),
      .clk_en_in(clk_en_in),
      .in_valid_in(s_q.hold_v),
      .in_data_in(s_q.hold),
      .in_ready_out(f_in_ready),
      .out_valid_out(f_out_valid),
      .out_ready_in(s_q.w_act),
      .out_data_out(f_out)
   );

   impedance_cal #(
      .CAL_PERIOD(CAL_PERIOD)
   ) u_cal (
      .clk_in(mclk_in),
      .rst_in(rst_in),
      .clk_en_in(clk_en_in),
      .ext_en_in(s_q.mode.imp),
      .ext_cmp_in(impedance_ref_pin_in),
      .int_cmp_in(internal_ref_cmp_in),
      .code_out(cal_code)
   );

   always_comb begin
      cmd_kind_t kind;
      logic iss_v;
      logic iss_wr;
      pipe_t ent;
      logic ms_v;
      logic [ADDR_W-1:0] ms_word;
      logic [ADDR_W-1:0] full;
      logic [3:0] bl;
      logic [3:0] rl;
      logic beat_v;
      logic [3:0] beat_i;
      pipe_t rsrc;
      logic edge_w;
      mode_t nm;

      s_d = s_q;
      kind = cmd_kind(s_q.c2);
      iss_v = 1'b0;
      iss_wr = 1'b0;
      ent = '0;
      ms_v = 1'b0;
      ms_word = '0;
      full = '0;
      bl = burst_beats(s_q.mode.bl);
      rl = read_latency(s_q.mode.cfg);
      beat_v = 1'b0;
      beat_i = '0;
      rsrc = s_q.r_cur;
      edge_w = s_q.wck2 && !s_q.wck3;
      nm = s_q.mode;
      mem_we = 1'b0;
      mem_widx = '0;
      mem_wdata = '0;

      // Two-stage pin sampling
      s_d.c1 = '{cs_n: chip_sel_n_in, we_n: write_en_n_in, ref_n: refresh_n_in,
                 bank: bank_in, addr: addr_in};
      s_d.c2 = s_q.c1;
      s_d.wck1 = write_data_clock_in;
      s_d.wck2 = s_q.wck1;
      s_d.wck3 = s_q.wck2;
      s_d.b1 = '{mask: data_mask_in, data: write_data_in};
      s_d.b2 = s_q.b1;
      s_d.ref_pulse = 1'b0;

      // Pending bursts keep moving
      s_d.rp = {pipe_t'('0), s_q.rp[PIPE_LEN-1:1]};
      s_d.wp = {pipe_t'('0), s_q.wp[PIPE_LEN-1:1]};

      case (s_q.ph)
         PH_FIRST: begin
            case (kind)
               K_READ, K_WRITE: begin
                  if (s_q.mode.mux) begin
                     s_d.ph = PH_SECOND;
                     s_d.pend = kind;
                     s_d.pbank = s_q.c2.bank;
                     s_d.pfirst = s_q.c2.addr;
                  end else begin
                     iss_v = 1'b1;
                     iss_wr = (kind == K_WRITE);
                     ent.bank = s_q.c2.bank;
                     ent.addr = s_q.c2.addr;
                  end
               end
               K_MRS: begin
                  if (s_q.mode.mux) begin
                     s_d.ph = PH_SECOND;
                     s_d.pend = K_MRS;
                     s_d.pfirst = s_q.c2.addr;
                  end else begin
                     ms_v = 1'b1;
                     ms_word = s_q.c2.addr;
                  end
               end
               K_REF: begin
                  s_d.ref_pulse = 1'b1;
               end
               default: begin
               end
            endcase
         end
         PH_SECOND: begin
            // Second half, strobes ignored
            full = mux_join(s_q.pfirst, s_q.c2.addr);
            s_d.ph = PH_FIRST;
            if (s_q.pend == K_MRS) begin
               ms_v = 1'b1;
               ms_word = full;
            end else begin
               iss_v = 1'b1;
               iss_wr = (s_q.pend == K_WRITE);
               ent.bank = s_q.pbank;
               ent.addr = full;
            end
         end
         default: begin
            s_d.ph = PH_FIRST;
         end
      endcase

      // Mux issue lands one cycle later
      if (iss_v) begin
         ent.valid = 1'b1;
         ent.addr = ent.addr & addr_mask(s_q.mode.bl, ORG_X18);
         if (iss_wr) begin
            s_d.wp[rl - 4'h1] = ent;
         end else begin
            s_d.rp[rl - 4'h2] = ent;
         end
      end

      // Loop lock counter and mode word load
      if (s_q.dll_cnt != '0) begin
         s_d.dll_cnt = s_q.dll_cnt - 11'h001;
         if (s_q.dll_cnt == 11'h001) begin
            s_d.dll_lock = 1'b1;
         end
      end
      if (ms_v) begin
         nm.cfg = ms_word[MODE_CFG_LSB +: 3];
         nm.bl = ms_word[MODE_BL_LSB +: 2];
         nm.mux = ms_word[MODE_MUX_BIT];
         nm.dll = ms_word[MODE_DLL_BIT];
         nm.imp = ms_word[MODE_IMP_BIT];
         nm.on_die_termination = ms_word[MODE_ODT_BIT];
         s_d.mode = nm;
         if (!nm.dll) begin
            s_d.dll_lock = 1'b0;
            s_d.dll_cnt = '0;
         end else if (!s_q.mode.dll) begin
            s_d.dll_lock = 1'b0;
            s_d.dll_cnt = 11'(DLL_LOCK_CYCLES);
         end
      end

      // Read burst engine
      if (s_q.rp[0].valid) begin
         s_d.r_act = 1'b1;
         s_d.r_cur = s_q.rp[0];
         s_d.r_cnt = 4'h1;
         rsrc = s_q.rp[0];
         beat_v = 1'b1;
      end else if (s_q.r_act && s_q.r_cnt < bl) begin
         beat_i = s_q.r_cnt;
         s_d.r_cnt = s_q.r_cnt + 4'h1;
         beat_v = 1'b1;
      end else begin
         s_d.r_act = 1'b0;
      end
      if (beat_v) begin
         s_d.rdata = mem[mem_index(rsrc, beat_i)];
      end
      s_d.rd_oe_n = !beat_v;
      s_d.rvalid = s_q.rp[1].valid || (beat_v && beat_i != bl - 4'h1);
      s_d.qclk = !s_q.qclk;
      s_d.qclk_n = s_q.qclk;
      s_d.rterm = nm.on_die_termination && !beat_v;
      s_d.wterm = nm.on_die_termination;

      // Write beat capture
      if (s_q.hold_v && f_in_ready) begin
         s_d.hold_v = 1'b0;
      end
      if (edge_w) begin
         if (s_d.hold_v) begin
            s_d.overrun = 1'b1;
         end else begin
            s_d.hold = s_q.b2;
            s_d.hold_v = 1'b1;
         end
      end

      // Write burst engine
      if (s_q.w_act && f_out_valid) begin
         mem_we = !f_out.mask;
         mem_widx = mem_index(s_q.w_cur, s_q.w_cnt);
         mem_wdata = f_out.data;
         s_d.w_cnt = s_q.w_cnt + 4'h1;
         if (s_q.w_cnt == bl - 4'h1) begin
            s_d.w_act = 1'b0;
         end
      end
      if (s_q.wp[0].valid) begin
         s_d.w_act = 1'b1;
         s_d.w_cur = s_q.wp[0];
         s_d.w_cnt = '0;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         s_q <= '0;
         s_q.c1.cs_n <= 1'b1;
         s_q.c2.cs_n <= 1'b1;
         s_q.ph <= PH_FIRST;
         s_q.pend <= K_NONE;
         s_q.mode <= MODE_RESET;
         s_q.rd_oe_n <= 1'b1;
         s_q.qclk_n <= 1'b1;
      end else if (clk_en_in) begin
         s_q <= s_d;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (clk_en_in && mem_we) begin
         mem[mem_widx] <= mem_wdata;
      end
   end

   assign read_data_out = s_q.rdata;
   assign read_data_oe_n_out = s_q.rd_oe_n;
   assign read_valid_flag_out = s_q.rvalid;
   assign read_data_clock_out = s_q.qclk;
   assign read_data_clock_n_out = s_q.qclk_n;
   assign read_term_en_out = s_q.rterm;
   assign write_term_en_out = s_q.wterm;
   assign dll_locked_out = s_q.dll_lock;
   assign mux_mode_out = s_q.mode.mux;
   assign impedance_ext_out = s_q.mode.imp;
   assign impedance_code_out = cal_code;
   assign refresh_pulse_out = s_q.ref_pulse;
   assign write_overrun_out = s_q.overrun;
endmodule

// ==== hw/dram_pkg.sv ====
/*
 Shared types and constants for the memory command and data path.
 Assumes one clock domain in the device; pins arrive unsynchronised.
*/
package dram_pkg;

   localparam int ADDR_W = 22;
   localparam int BANK_W = 3;
   localparam int DATA_W = 18;
   localparam int MUX_LINES = 11;
   localparam int PIPE_LEN = 8;
   localparam int DLL_LOCK_CYCLES = 1024;
   localparam int CODE_W = 6;
   localparam logic [CODE_W-1:0] CODE_INTERNAL_50 = 6'h20;

   // Mode word field positions
   localparam int MODE_CFG_LSB = 0;
   localparam int MODE_BL_LSB = 3;
   localparam int MODE_MUX_BIT = 5;
   localparam int MODE_DLL_BIT = 7;
   localparam int MODE_IMP_BIT = 8;
   localparam int MODE_ODT_BIT = 9;

   // Burst length codes
   localparam logic [1:0] BL_CODE_2 = 2'h0;
   localparam logic [1:0] BL_CODE_4 = 2'h1;

   // Address bit carried on each ball in the two halves
   localparam int FIRST_MAP [MUX_LINES] = '{0, 3, 4, 5, 8, 9, 10, 13, 14, 17, 18};
   localparam int SECOND_MAP [MUX_LINES] = '{20, 1, 2, 21, 6, 7, 19, 11, 12, 16, 15};

   typedef enum logic [2:0] {K_NONE, K_MRS, K_READ, K_WRITE, K_REF} cmd_kind_t;

   typedef struct packed {
      logic cs_n;
      logic we_n;
      logic ref_n;
      logic [BANK_W-1:0] bank;
      logic [ADDR_W-1:0] addr;
   } cmd_t;

   typedef struct packed {
      logic on_die_termination;
      logic imp;
      logic dll;
      logic mux;
      logic [1:0] bl;
      logic [2:0] cfg;
   } mode_t;

   localparam mode_t MODE_RESET = '{on_die_termination: 1'b0, imp: 1'b0, dll: 1'b0, mux: 1'b0, bl: 2'h0, cfg: 3'h0};

   typedef struct packed {
      logic mask;
      logic [DATA_W-1:0] data;
   } beat_t;

   typedef struct packed {
      logic valid;
      logic [BANK_W-1:0] bank;
      logic [ADDR_W-1:0] addr;
   } pipe_t;

   function automatic cmd_kind_t cmd_kind(input cmd_t c);
      cmd_kind_t k;
      k = K_NONE;
      if (!c.cs_n) begin
         case ({c.we_n, c.ref_n})
            2'b00: k = K_MRS;
            2'b11: k = K_READ;
            2'b01: k = K_WRITE;
            2'b10: k = K_REF;
            default: k = K_NONE;
         endcase
      end
      return k;
   endfunction

   function automatic logic [3:0] read_latency(input logic [2:0] cfg);
      logic [3:0] rl;
      case (cfg)
         3'h2: rl = 4'h6;
         3'h3: rl = 4'h8;
         3'h4: rl = 4'h3;
         3'h5: rl = 4'h5;
         default: rl = 4'h4;
      endcase
      return rl;
   endfunction

   function automatic logic [3:0] burst_beats(input logic [1:0] bl);
      return (bl == BL_CODE_2) ? 4'h2 : (bl == BL_CODE_4) ? 4'h4 : 4'h8;
   endfunction

endpackage

// ==== hw/beat_fifo.sv ====
/*
 Small synchronous FIFO with valid/ready on both sides.
 Assumes both sides run on the same clock and clock enable.
*/
`timescale 1ns/1ps
module beat_fifo #(
   parameter int WIDTH = 19,
   parameter int DEPTH = 4
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic clk_en_in,
   input wire logic in_valid_in,
   input wire logic [WIDTH-1:0] in_data_in,
   output logic in_ready_out,
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [WIDTH-1:0] out_data_out
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   generate
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
         $error("beat_fifo depth must be a power of two of at least 2");
      end
   endgenerate

   typedef struct packed {
      logic [PW:0] wr;
      logic [PW:0] rd;
   } fifo_state_t;

   fifo_state_t s_q;
   fifo_state_t s_d;
   logic [WIDTH-1:0] mem [DEPTH];
   logic push;
   logic pop;
   logic full;
   logic empty;

   assign full = (s_q.wr[PW] != s_q.rd[PW]) && (s_q.wr[PW-1:0] == s_q.rd[PW-1:0]);
   assign empty = (s_q.wr == s_q.rd);
   assign push = in_valid_in && !full;
   assign pop = out_ready_in && !empty;
   assign in_ready_out = !full;
   assign out_valid_out = !empty;
   assign out_data_out = mem[s_q.rd[PW-1:0]];

   always_comb begin
      s_d = s_q;
      if (push) begin
         s_d.wr = s_q.wr + 1'b1;
      end
      if (pop) begin
         s_d.rd = s_q.rd + 1'b1;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         s_q <= '0;
      end else if (clk_en_in) begin
         s_q <= s_d;
      end
   end

   always_ff @(posedge clk_in) begin
      if (clk_en_in && push) begin
         mem[s_q.wr[PW-1:0]] <= in_data_in;
      end
   end
endmodule

// ==== hw/impedance_cal.sv ====
/*
 Periodic output impedance calibration, external resistor or internal target.
 Assumes comparator levels arrive from outside the clock domain.
*/
`timescale 1ns/1ps
module impedance_cal #(
   parameter int CAL_PERIOD = 256
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic clk_en_in,
   input wire logic ext_en_in,
   input wire logic ext_cmp_in,
   input wire logic int_cmp_in,
   output logic [dram_pkg::CODE_W-1:0] code_out
);
   import dram_pkg::*;

   generate
      if (CAL_PERIOD < 2 || CAL_PERIOD > 65535) begin : g_bad_period
         $error("impedance_cal period out of range");
      end
   endgenerate

   typedef struct packed {
      logic e1;
      logic e2;
      logic i1;
      logic i2;
      logic [15:0] cnt;
      logic [CODE_W-1:0] work;
      logic [CODE_W-1:0] live;
   } cal_state_t;

   cal_state_t s_q;
   cal_state_t s_d;
   logic cmp;

   always_comb begin
      s_d = s_q;
      s_d.e1 = ext_cmp_in;
      s_d.e2 = s_q.e1;
      s_d.i1 = int_cmp_in;
      s_d.i2 = s_q.i1;
      cmp = ext_en_in ? s_q.e2 : s_q.i2;
      if (s_q.cnt == 16'(CAL_PERIOD - 1)) begin
         s_d.cnt = '0;
         // Step code, publish previous
         if (cmp && s_q.work != '1) begin
            s_d.work = s_q.work + 1'b1;
         end else if (!cmp && s_q.work != '0) begin
            s_d.work = s_q.work - 1'b1;
         end
         s_d.live = s_q.work;
      end else begin
         s_d.cnt = s_q.cnt + 16'h0001;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         s_q <= '{e1: 1'b0, e2: 1'b0, i1: 1'b0, i2: 1'b0, cnt: 16'h0000,
                  work: CODE_INTERNAL_50, live: CODE_INTERNAL_50};
      end else if (clk_en_in) begin
         s_q <= s_d;
      end
   end

   assign code_out = s_q.live;
endmodule

// ==== dv/dram_cmd_datapath_checker.sv ====
/*
 Assertions on read bursts, termination, clocks, refresh, lock.
 Assumes a bind to the datapath top.
*/
`timescale 1ns/1ps
module dram_cmd_datapath_checker (
   input wire logic mclk_in,
   input wire logic rst_in,
   input wire logic chip_sel_n_in,
   input wire logic write_en_n_in,
   input wire logic refresh_n_in,
   input wire logic read_data_oe_n_out,
   input wire logic read_valid_flag_out,
   input wire logic read_data_clock_out,
   input wire logic read_data_clock_n_out,
   input wire logic read_term_en_out,
   input wire logic write_term_en_out,
   input wire logic dll_locked_out,
   input wire logic refresh_pulse_out
);
   logic [3:0] rd_age_q;
   logic [10:0] ms_age_q;
   wire rd_pins = !chip_sel_n_in && write_en_n_in && refresh_n_in;
   wire ms_pins = !chip_sel_n_in && !write_en_n_in && !refresh_n_in;
   wire rf_pins = !chip_sel_n_in && write_en_n_in && !refresh_n_in;
   // Cycles since read or mode set pins
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         rd_age_q <= 4'hf;
         ms_age_q <= 11'h7ff;
      end else begin
         rd_age_q <= rd_pins ? 4'h0 : rd_age_q + {3'h0, rd_age_q != 4'hf};
         ms_age_q <= ms_pins ? 11'h0 : ms_age_q + {10'h0, ms_age_q != 11'h7ff};
      end
   end
   default clocking @(posedge mclk_in);
   endclocking
   default disable iff (rst_in);
   AST_FLAG_LEADS: assert property ($fell(read_data_oe_n_out) |-> $past(read_valid_flag_out))
      else $error("flag not ahead of beat");
   AST_TERM_OFF: assert property (!read_data_oe_n_out |-> !read_term_en_out)
      else $error("read term on while driving");
   AST_TERM_BACK: assert property ($rose(read_data_oe_n_out) |-> read_term_en_out == write_term_en_out)
      else $error("read term not restored");
   AST_FLAG_DROP: assert property ($fell(read_valid_flag_out) |-> !read_data_oe_n_out)
      else $error("flag fell off a beat");
   AST_FLOAT: assert property (!read_data_oe_n_out && !read_valid_flag_out |=> read_data_oe_n_out)
      else $error("pins driven after burst");
   AST_CLK_TOGGLE: assert property (!$past(rst_in) |-> read_data_clock_out != $past(read_data_clock_out))
      else $error("output clock stopped");
   AST_CLK_PAIR: assert property (read_data_clock_n_out != read_data_clock_out)
      else $error("clock pair not inverse");
   AST_REFRESH: assert property (refresh_pulse_out |-> $past(rf_pins, 3))
      else $error("refresh pulse without command");
   AST_READ_LAT: assert property ($rose(read_valid_flag_out) |-> rd_age_q >= 4'h2 && rd_age_q <= 4'he)
      else $error("flag without recent read");
   AST_DLL_LOCK: assert property ($rose(dll_locked_out) |-> ms_age_q >= 11'h3fe && ms_age_q <= 11'h40a)
      else $error("loop lock at wrong time");
endmodule
bind dram_cmd_datapath dram_cmd_datapath_checker i_chk (.mclk_in(mclk_in), .rst_in(rst_in),
   .chip_sel_n_in(chip_sel_n_in), .write_en_n_in(write_en_n_in), .refresh_n_in(refresh_n_in),
   .read_data_oe_n_out(read_data_oe_n_out), .read_valid_flag_out(read_valid_flag_out),
   .read_data_clock_out(read_data_clock_out), .read_data_clock_n_out(read_data_clock_n_out),
   .read_term_en_out(read_term_en_out), .write_term_en_out(write_term_en_out),
   .dll_locked_out(dll_locked_out), .refresh_pulse_out(refresh_pulse_out));

// ==== dv/ctl_model.sv ====
/*
 Controller model: command pins, write beats, write clock.
 Assumes tasks are called one at a time after a clock edge.
*/
`timescale 1ns/1ps
module ctl_model (
   input wire logic mclk_in,
   output logic cs_n_out,
   output logic we_n_out,
   output logic ref_n_out,
   output logic [2:0] bank_out,
   output logic [21:0] addr_out,
   output logic [17:0] wdata_out,
   output logic mask_out,
   output logic wclk_out
);
   import dram_pkg::*;
   initial begin
      {cs_n_out, we_n_out, ref_n_out, bank_out, addr_out, wdata_out, mask_out, wclk_out} = {3'h7, 45'h0};
   end
   // Command held rep cycles, then mux second half
   task automatic cmd(input logic [1:0] s, input logic [21:0] a, input logic m, input int rep);
      logic [21:0] x;
      logic [21:0] y;
      {x, y} = 44'h0;
      for (int i = 0; i < MUX_LINES; i++) begin
         x[FIRST_MAP[i]] = a[FIRST_MAP[i]];
         y[FIRST_MAP[i]] = a[SECOND_MAP[i]];
      end
      @(posedge mclk_in);
      #1;
      {cs_n_out, we_n_out, ref_n_out} = {1'b0, s};
      addr_out = m ? x : a;
      repeat (rep - 1) @(posedge mclk_in);
      if (m) begin
         @(posedge mclk_in);
         #1;
         cs_n_out = 1'b1;
         addr_out = y;
      end
      @(posedge mclk_in);
      #1;
      cs_n_out = 1'b1;
      addr_out = ~addr_out;
   endtask
   // One beat per 200 ns write clock
   task automatic beat(input logic [17:0] d, input logic m);
      wdata_out = d;
      mask_out = m;
      #37 wclk_out = 1'b1;
      #100 wclk_out = 1'b0;
      wdata_out = ~d;
      #63;
   endtask
endmodule

// ==== dv/dram_cmd_datapath_tb.sv ====
/*
 Bench for the command and data path via the controller model.
 Assumes default organisation, short calibration period.
*/
`timescale 1ns/1ps
module dram_cmd_datapath_tb;
   import dram_pkg::*;
   logic mclk, rst, cs_n, we_n, ref_n, dmask, wclk, zq_cmp, int_cmp;
   logic oe_n, rvalid, qclk, qclk_n, rterm, wterm, locked, mux, iext, rpulse, ovr;
   logic [2:0] bank;
   logic [21:0] addr;
   logic [17:0] wdata, rdata;
   logic [5:0] code;
   logic [17:0] q[$];
   int miscompares = 0;
   int tests_run = 0;
   int lat0;
   ctl_model i_ctl (.mclk_in(mclk), .cs_n_out(cs_n), .we_n_out(we_n), .ref_n_out(ref_n), .bank_out(bank),
      .addr_out(addr), .wdata_out(wdata), .mask_out(dmask), .wclk_out(wclk));
   dram_cmd_datapath #(.CAL_PERIOD(8)) i_dut (.mclk_in(mclk), .rst_in(rst), .clk_en_in(1'b1),
      .chip_sel_n_in(cs_n), .write_en_n_in(we_n), .refresh_n_in(ref_n), .bank_in(bank), .addr_in(addr),
      .write_data_in(wdata), .data_mask_in(dmask), .write_data_clock_in(wclk), .impedance_ref_pin_in(zq_cmp),
      .internal_ref_cmp_in(int_cmp), .read_data_out(rdata), .read_data_oe_n_out(oe_n),
      .read_valid_flag_out(rvalid), .read_data_clock_out(qclk), .read_data_clock_n_out(qclk_n),
      .read_term_en_out(rterm), .write_term_en_out(wterm), .dll_locked_out(locked), .mux_mode_out(mux),
      .impedance_ext_out(iext), .impedance_code_out(code), .refresh_pulse_out(rpulse),
      .write_overrun_out(ovr));
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   task automatic check(input string what, input logic [21:0] seen, input logic [21:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic do_reset();
      rst = 1'b1;
      repeat (16) @(posedge mclk);
      #1;
      rst = 1'b0;
      repeat (3) @(posedge mclk);
      #1;
   endtask
   task automatic mode(input logic [21:0] w);
      i_ctl.cmd(2'b00, w, 1'b0, 1);
      repeat (6) @(posedge mclk);
      #1;
   endtask
   task automatic wr(input logic [21:0] a, input logic [17:0] d0, input logic m0, input logic [17:0] d1);
      i_ctl.cmd(2'b01, a, 1'b0, 1);
      i_ctl.beat(d0, m0);
      i_ctl.beat(d1, 1'b0);
      repeat (12) @(posedge mclk);
      #1;
   endtask
   task automatic rd(input logic [21:0] a, input logic [21:0] b, input int n, input logic m, output int lat);
      realtime t0;
      t0 = $realtime;
      q.delete();
      i_ctl.cmd(2'b11, a, m, 1);
      if (n > 2) begin
         i_ctl.cmd(2'b11, b, m, 1);
      end
      lat = 0;
      while (oe_n === 1'b1 && lat < 40) begin
         @(posedge mclk);
         #1;
         lat++;
      end
      if (oe_n !== 1'b0) begin
         check("read start", oe_n, 1'b0);
         stop_test();
      end
      lat = int'(($realtime - t0) / 25.0);
      repeat (n) begin
         check("beat driven", oe_n, 1'b0);
         q.push_back(rdata);
         @(posedge mclk);
         #1;
      end
      check("float after burst", oe_n, 1'b1);
      check("term back", rterm, wterm);
      repeat (4) @(posedge mclk);
      #1;
   endtask
   task automatic t_reset();
      check("loop off", locked, 1'b0);
      check("internal code", code, 6'h20);
      check("oe released", oe_n, 1'b1);
      check("no term", wterm, 1'b0);
      check("non-mux", mux, 1'b0);
   endtask
   task automatic t_imp();
      logic [5:0] c;
      int_cmp = 1'b1;
      repeat (60) @(posedge mclk);
      #1;
      check("internal recal", code > 6'h20, 1'b1);
      mode(22'h100);
      check("ext select", iext, 1'b1);
      c = code;
      {zq_cmp, int_cmp} = 2'h2;
      repeat (60) @(posedge mclk);
      #1;
      check("external recal", code > c, 1'b1);
      zq_cmp = 1'b0;
      mode(22'h000);
   endtask
   task automatic t_dll();
      int n;
      mode(22'h080);
      n = 0;
      while (locked !== 1'b1 && n < 1100) begin
         @(posedge mclk);
         #1;
         n++;
      end
      check("lock wait", n >= 1010 && n <= 1030, 1'b1);
      if (n >= 1100) begin
         stop_test();
      end
      mode(22'h000);
      check("lock cleared", locked, 1'b0);
   endtask
   task automatic t_rw();
      logic [17:0] e [4] = '{18'h1a5, 18'h3c7, 18'h111, 18'h222};
      wr(22'h10, 18'h1a5, 1'b0, 18'h2b6);
      wr(22'h46, 18'h111, 1'b0, 18'h222);
      wr(22'h10, 18'h0f0, 1'b1, 18'h3c7);
      rd(22'h10, 22'h46, 4, 1'b0, lat0);
      for (int i = 0; i < 4; i++) begin
         check("read beat", q[i], e[i]);
      end
   endtask
   task automatic t_lat();
      int l;
      int n;
      mode(22'h202);
      check("data term", wterm, 1'b1);
      rd(22'h10, 22'h0, 2, 1'b0, l);
      check("latency step", l - lat0, 2);
      mode(22'h220);
      check("mux mode", mux, 1'b1);
      rd(22'h46, 22'h0, 2, 1'b1, l);
      check("mux beat0", q[0], 18'h111);
      check("mux beat1", q[1], 18'h222);
      check("mux latency", l - lat0, 1);
      i_ctl.cmd(2'b10, 22'h0, 1'b0, 2);
      n = 0;
      repeat (8) begin
         n += (rpulse === 1'b1);
         @(posedge mclk);
         #1;
      end
      check("refresh pulses", n, 2);
   endtask
   task automatic t_ovr();
      repeat (7) i_ctl.beat(18'h155, 1'b0);
      check("fifo refused", ovr, 1'b1);
      do_reset();
      check("overrun cleared", ovr, 1'b0);
   endtask
   initial begin
      rst = 1'b1;
      {zq_cmp, int_cmp} = 2'h0;
      do_reset();
      t_reset();
      t_imp();
      t_dll();
      t_rw();
      t_lat();
      t_ovr();
      stop_test();
   end
endmodule
